// *** reference_positioning_control.sv ***
// Reference positioning controller with APB register slave
//
// Operation
// - Negative-edge source on input two, three or six starts on falling edge.
// - Positive-edge source starts positioning on rising edge of selected input.
// - Both-edge source starts positioning on any edge of selected input.
// - Distance zero stops the drive immediately at the reference event.
// - Distance in thousandths of a revolution, zero to one million revolutions, default 0.
// - Position is revolutions accumulated since the reference event.
// - Braking distance never shorter than f squared over 2*a*p.
// - Signed signal correction shifts the reference instant, default zero.
// - Signed load correction lengthens or shortens distance, default zero.
// - Action one holds until next edge, restarts in same direction.
// - Action two holds until next edge, restarts in opposite direction.
// - Action three stops the drive and switches the power stage off.
// - Action four holds for waiting time, restarts in same direction.
// - Action five holds for waiting time, restarts in opposite direction.
// - Reference during a ramp freezes output frequency at its value then.
// - Frequency held constant until braking point; distance independent of f.
// - Counted revolutions since the reference are readable.
// - Positioning only when the positioning mode is enabled.
`timescale 1ns/1ps
`default_nettype none
module reference_positioning_control #(
    parameter int unsigned TICK_CYCLES = ref_pos_pkg::TICK_CYCLES,
    parameter int unsigned MS_TICKS = ref_pos_pkg::MS_TICKS
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic digital_input_two,
    input wire logic digital_input_three,
    input wire logic digital_input_six,
    input wire logic [15:0] drive_freq,
    input wire ref_pos_pkg::apb_req_t apb_req,
    output var ref_pos_pkg::apb_rsp_t apb_rsp_q,
    output logic [15:0] freq_ref_q,
    output logic freq_own_q,
    output logic stop_q,
    output logic power_off_q,
    output logic reverse_q,
    output logic restart_q
);
    logic rise2, fall2, rise3, fall3, rise6, fall6, ref_edge;
    logic [15:0] tick_cnt_q;
    logic tick_q, ms_tick;
    logic [6:0] ms_cnt_q;
    logic en_q;
    ref_pos_pkg::action_t act_q;
    logic [7:0] src_q;
    logic [29:0] dist_q, rev_q;
    logic signed [15:0] corr_q, load_q;
    logic [21:0] wait_q, timer_q;
    logic [15:0] decel_q;
    logic [3:0] poles_q;
    ref_pos_pkg::state_t state_q;
    logic [39:0] rev_acc_q;
    logic [23:0] dec_acc_q;
    logic setup, access_done, wr_en, addr_hit, timed_act, rev_act;
    logic [31:0] rd_data;
    logic event_now, start_now, post_go, release_now, decel_due;
    logic signed [32:0] target_s;
    logic [31:0] remain;
    logic [63:0] brake_need, fsq;
    logic [17:0] rev_step;
    logic rev_sub, dec_sub;

    // Input synchronisers
    edge_sync u_sync_two (.sys_clk(sys_clk), .rst(rst),
        .pin_in(digital_input_two), .rise_q(rise2), .fall_q(fall2));
    edge_sync u_sync_three (.sys_clk(sys_clk), .rst(rst),
        .pin_in(digital_input_three), .rise_q(rise3), .fall_q(fall3));
    edge_sync u_sync_six (.sys_clk(sys_clk), .rst(rst),
        .pin_in(digital_input_six), .rise_q(rise6), .fall_q(fall6));

    // Unknown source codes never trigger
    always_comb begin
        case (src_q)
            ref_pos_pkg::SRC_IN2_NEG: ref_edge = fall2;
            ref_pos_pkg::SRC_IN3_NEG: ref_edge = fall3;
            ref_pos_pkg::SRC_IN6_NEG: ref_edge = fall6;
            ref_pos_pkg::SRC_IN2_POS: ref_edge = rise2;
            ref_pos_pkg::SRC_IN3_POS: ref_edge = rise3;
            ref_pos_pkg::SRC_IN6_POS: ref_edge = rise6;
            ref_pos_pkg::SRC_IN2_BOTH: ref_edge = rise2 | fall2;
            ref_pos_pkg::SRC_IN3_BOTH: ref_edge = rise3 | fall3;
            ref_pos_pkg::SRC_IN6_BOTH: ref_edge = rise6 | fall6;
            default: ref_edge = 1'b0;
        endcase
    end

    // 10 us time base and 1 ms sub-divider
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tick_cnt_q <= 16'h0000;
            tick_q <= 1'b0;
        end else if (post_go || tick_cnt_q == 16'(TICK_CYCLES - 1)) begin
            // Restart at park entry so a wait lasts its full length
            tick_cnt_q <= 16'h0000;
            tick_q <= !post_go;
        end else begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ms_cnt_q <= 7'h00;
        end else if (tick_q || post_go) begin
            ms_cnt_q <= ms_tick || post_go ? 7'h00 : ms_cnt_q + 7'h01;
        end
    end
    assign ms_tick = tick_q && ms_cnt_q == 7'(MS_TICKS - 1);

    // APB slave: one wait-free access phase, answer registered at setup
    assign setup = apb_req.psel && !apb_req.penable;
    assign access_done = apb_req.psel && apb_req.penable && apb_rsp_q.pready;
    assign addr_hit = apb_req.paddr <= ref_pos_pkg::REVS_OFS
        && apb_req.paddr[1:0] == 2'h0;
    assign wr_en = access_done && apb_req.pwrite && !apb_rsp_q.pslverr;

    always_comb begin
        rd_data = 32'h00000000;
        case (apb_req.paddr)
            ref_pos_pkg::CTRL_OFS: rd_data = {16'h0000, src_q, 1'b0, act_q,
                3'h0, en_q};
            ref_pos_pkg::DIST_OFS: rd_data = {2'h0, dist_q};
            ref_pos_pkg::SIGCORR_OFS: rd_data = {16'h0000, corr_q};
            ref_pos_pkg::LOADCORR_OFS: rd_data = {16'h0000, load_q};
            ref_pos_pkg::WAIT_OFS: rd_data = {10'h000, wait_q};
            ref_pos_pkg::DECEL_OFS: rd_data = {16'h0000, decel_q};
            ref_pos_pkg::POLES_OFS: rd_data = {28'h0000000, poles_q};
            ref_pos_pkg::STATUS_OFS: rd_data = {24'h000000, power_off_q,
                stop_q, freq_own_q, reverse_q, 1'b0, state_q};
            ref_pos_pkg::REVS_OFS: rd_data = {2'h0, rev_q};
            default: rd_data = 32'h00000000;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            apb_rsp_q <= '0;
        end else begin
            apb_rsp_q.pready <= setup;
            if (setup) begin
                apb_rsp_q.pslverr <= !addr_hit;
                apb_rsp_q.prdata <= rd_data;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            en_q <= 1'b0;
            act_q <= ref_pos_pkg::ACT_END;
            src_q <= ref_pos_pkg::SRC_RST;
            dist_q <= ref_pos_pkg::DIST_RST;
            corr_q <= ref_pos_pkg::SIGCORR_RST;
            load_q <= ref_pos_pkg::LOADCORR_RST;
            wait_q <= ref_pos_pkg::WAIT_RST;
            decel_q <= ref_pos_pkg::DECEL_RST;
            poles_q <= ref_pos_pkg::POLES_RST;
        end else if (wr_en) begin
            case (apb_req.paddr)
                ref_pos_pkg::CTRL_OFS: begin
                    en_q <= apb_req.pwdata[ref_pos_pkg::CTRL_EN_BIT];
                    // Codes 6 and 7 fall back to plain end of positioning
                    act_q <= apb_req.pwdata[ref_pos_pkg::CTRL_ACT_LSB +: 3] > 3'h5
                        ? ref_pos_pkg::ACT_END
                        : ref_pos_pkg::action_t'(
                            apb_req.pwdata[ref_pos_pkg::CTRL_ACT_LSB +: 3]);
                    src_q <= apb_req.pwdata[ref_pos_pkg::CTRL_SRC_LSB +: 8];
                end
                ref_pos_pkg::DIST_OFS: dist_q <= apb_req.pwdata[29:0] >
                    ref_pos_pkg::DIST_MAX ? ref_pos_pkg::DIST_MAX
                    : apb_req.pwdata[29:0];
                ref_pos_pkg::SIGCORR_OFS: corr_q <= apb_req.pwdata[15:0];
                ref_pos_pkg::LOADCORR_OFS: load_q <= apb_req.pwdata[15:0];
                ref_pos_pkg::WAIT_OFS: wait_q <= apb_req.pwdata[21:0] >
                    ref_pos_pkg::WAIT_MAX ? ref_pos_pkg::WAIT_MAX
                    : apb_req.pwdata[21:0];
                ref_pos_pkg::DECEL_OFS: decel_q <= apb_req.pwdata[15:0] == 16'h0000
                    ? 16'h0001 : apb_req.pwdata[15:0];
                ref_pos_pkg::POLES_OFS: poles_q <= apb_req.pwdata[3:0] == 4'h0
                    ? 4'h1 : apb_req.pwdata[3:0];
                default: ;
            endcase
        end
    end

    // Sequencing terms
    assign timed_act = act_q == ref_pos_pkg::ACT_WAIT_TIME
        || act_q == ref_pos_pkg::ACT_REV_TIME;
    assign rev_act = act_q == ref_pos_pkg::ACT_REV_EDGE
        || act_q == ref_pos_pkg::ACT_REV_TIME;
    assign event_now = state_q == ref_pos_pkg::ST_IDLE && en_q && ref_edge;
    assign start_now = (event_now && !corr_q[15])
        || (state_q == ref_pos_pkg::ST_DELAY && timer_q == 22'h000000);
    assign post_go = (start_now && dist_q == 30'h00000000)
        || (state_q == ref_pos_pkg::ST_DECEL && freq_ref_q == 16'h0000);
    assign release_now = state_q == ref_pos_pkg::ST_PARK && (timed_act
        ? timer_q == 22'h000000 : ref_edge);

    // Effective target includes load correction, clamped at zero
    assign target_s = $signed({3'b000, dist_q})
        + $signed({{17{load_q[15]}}, load_q});
    assign remain = target_s[32] || target_s[31:0] <= {2'h0, rev_q}
        ? 32'h00000000 : target_s[31:0] - {2'h0, rev_q};
    // Braking point: remaining * 20 * a * p <= f^2 (mrev, 0.01 Hz, Hz/s)
    assign brake_need = {32'h00000000, remain} * {48'h000000000000, decel_q}
        * {60'h000000000000000, poles_q} * ref_pos_pkg::BRAKE_SCALE;
    assign fsq = {32'h00000000, 32'(freq_ref_q) * 32'(freq_ref_q)};
    assign decel_due = remain == 32'h00000000 || brake_need <= fsq;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= ref_pos_pkg::ST_IDLE;
            timer_q <= 22'h000000;
        end else if (!en_q) begin
            state_q <= ref_pos_pkg::ST_IDLE;
            timer_q <= 22'h000000;
        end else if (post_go) begin
            // Actions zero and three end here, others park the drive
            state_q <= act_q == ref_pos_pkg::ACT_END
                || act_q == ref_pos_pkg::ACT_OFF
                ? ref_pos_pkg::ST_STOP : ref_pos_pkg::ST_PARK;
            timer_q <= wait_q;
        end else if (start_now) begin
            state_q <= ref_pos_pkg::ST_TRAVEL;
        end else begin
            unique case (state_q)
                ref_pos_pkg::ST_IDLE: if (event_now) begin
                    state_q <= ref_pos_pkg::ST_DELAY;
                    timer_q <= 22'(16'(-corr_q));
                end
                ref_pos_pkg::ST_DELAY: if (tick_q) begin
                    timer_q <= timer_q - 22'h000001;
                end
                ref_pos_pkg::ST_TRAVEL: if (decel_due) begin
                    state_q <= ref_pos_pkg::ST_DECEL;
                end
                ref_pos_pkg::ST_DECEL: ;
                ref_pos_pkg::ST_PARK: begin
                    if (release_now) begin
                        state_q <= ref_pos_pkg::ST_IDLE;
                    end else if (ms_tick && timer_q != 22'h000000) begin
                        timer_q <= timer_q - 22'h000001;
                    end
                end
                ref_pos_pkg::ST_STOP: ;
            endcase
        end
    end

    // Frequency: tracks the drive while idle, frozen at the event
    assign dec_sub = dec_acc_q >= ref_pos_pkg::DEC_UNIT;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            freq_ref_q <= 16'h0000;
            dec_acc_q <= 24'h000000;
        end else begin
            unique case (state_q)
                ref_pos_pkg::ST_IDLE: begin
                    freq_ref_q <= drive_freq;
                    dec_acc_q <= 24'h000000;
                end
                ref_pos_pkg::ST_DELAY, ref_pos_pkg::ST_TRAVEL: ;
                ref_pos_pkg::ST_DECEL: begin
                    dec_acc_q <= dec_acc_q + (tick_q ? {8'h00, decel_q} : 24'h000000)
                        - (dec_sub ? ref_pos_pkg::DEC_UNIT : 24'h000000);
                    if (dec_sub && freq_ref_q != 16'h0000) begin
                        freq_ref_q <= freq_ref_q - 16'h0001;
                    end
                end
                ref_pos_pkg::ST_PARK, ref_pos_pkg::ST_STOP: freq_ref_q <= 16'h0000;
            endcase
            if (post_go) begin
                freq_ref_q <= 16'h0000;
            end
        end
    end

    // Revolutions in mrev from integrated frequency; one step per clock
    assign rev_step = ref_pos_pkg::REV_STEP_UNIT * {14'h0000, poles_q};
    assign rev_sub = rev_acc_q >= {22'h000000, rev_step};
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rev_q <= 30'h00000000;
            rev_acc_q <= 40'h0000000000;
        end else if (start_now) begin
            rev_q <= 30'h00000000;
            // Positive correction credits distance run before the event
            rev_acc_q <= corr_q[15] ? 40'h0000000000
                : 40'(freq_ref_q) * {25'h0000000, corr_q[14:0]};
        end else begin
            rev_acc_q <= rev_acc_q + (tick_q ? 40'(freq_ref_q) : 40'h0000000000)
                - (rev_sub ? {22'h000000, rev_step} : 40'h0000000000);
            if (rev_sub) begin
                rev_q <= rev_q + 30'h00000001;
            end
        end
    end

    // Drive-stage controls
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            freq_own_q <= 1'b0;
            stop_q <= 1'b0;
            power_off_q <= 1'b0;
            reverse_q <= 1'b0;
            restart_q <= 1'b0;
        end else begin
            freq_own_q <= state_q != ref_pos_pkg::ST_IDLE;
            stop_q <= state_q == ref_pos_pkg::ST_PARK
                || state_q == ref_pos_pkg::ST_STOP;
            power_off_q <= state_q == ref_pos_pkg::ST_STOP
                && act_q == ref_pos_pkg::ACT_OFF;
            restart_q <= release_now && en_q;
            if (release_now && en_q && rev_act) begin
                reverse_q <= !reverse_q;
            end
        end
    end

    property p_start(logic edge_in, logic [7:0] code);
        @(posedge sys_clk) disable iff (rst)
        state_q == ref_pos_pkg::ST_IDLE && en_q && src_q == code && edge_in
            |=> state_q != ref_pos_pkg::ST_IDLE;
    endproperty

    sequence s_release_rev;
        release_now && en_q && rev_act;
    endsequence

    chk_neg_edge_start: assert property (p_start(fall2, ref_pos_pkg::SRC_IN2_NEG))
        else $error("falling edge did not start positioning");
    chk_pos_edge_start: assert property (p_start(rise3, ref_pos_pkg::SRC_IN3_POS))
        else $error("rising edge did not start positioning");
    chk_both_edge_start: assert property (p_start(rise6 || fall6,
        ref_pos_pkg::SRC_IN6_BOTH))
        else $error("any edge did not start positioning");
    chk_zero_dist_stop: assert property (@(posedge sys_clk) disable iff (rst)
        start_now && en_q && dist_q == 30'h00000000 |=> ##1 stop_q && freq_ref_q == 16'h0000)
        else $error("zero distance did not stop at once");
    chk_rev_restart: assert property (@(posedge sys_clk) disable iff (rst)
        start_now && en_q |=> rev_q == 30'h00000000)
        else $error("revolution count not cleared at event");
    chk_freeze_freq: assert property (@(posedge sys_clk) disable iff (rst)
        event_now && !corr_q[15] && dist_q != 30'h00000000
            |=> freq_ref_q == $past(drive_freq) ##1 freq_ref_q == $past(freq_ref_q))
        else $error("frequency not frozen at event");
    chk_hold_freq: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == ref_pos_pkg::ST_TRAVEL && en_q && !decel_due && !start_now
            |=> freq_ref_q == $past(freq_ref_q))
        else $error("frequency moved before braking point");
    chk_power_off: assert property (@(posedge sys_clk) disable iff (rst)
        post_go && en_q && act_q == ref_pos_pkg::ACT_OFF
            |=> state_q == ref_pos_pkg::ST_STOP ##1 (power_off_q && stop_q)[*2])
        else $error("power stage not switched off");
    chk_reverse_dir: assert property (@(posedge sys_clk) disable iff (rst)
        s_release_rev |=> restart_q && reverse_q != $past(reverse_q))
        else $error("restart not in opposite direction");
    chk_disable_idle: assert property (@(posedge sys_clk) disable iff (rst)
        !en_q |=> state_q == ref_pos_pkg::ST_IDLE ##1 !freq_own_q)
        else $error("positioning active while disabled");
endmodule : reference_positioning_control
`default_nettype wire

// *** ref_pos_pkg.sv ***
// Constants, types and register map of the reference positioning block
package ref_pos_pkg;

    // Clock and time base
    localparam int unsigned CLK_FREQ_HZ = 200_000_000;
    localparam int unsigned TICK_US = 10;
    localparam int unsigned TICK_CYCLES = CLK_FREQ_HZ / 1_000_000 * TICK_US;
    localparam int unsigned MS_US = 1000;
    localparam int unsigned MS_TICKS = MS_US / TICK_US;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] DIST_OFS = 8'h04;
    localparam logic [7:0] SIGCORR_OFS = 8'h08;
    localparam logic [7:0] LOADCORR_OFS = 8'h0C;
    localparam logic [7:0] WAIT_OFS = 8'h10;
    localparam logic [7:0] DECEL_OFS = 8'h14;
    localparam logic [7:0] POLES_OFS = 8'h18;
    localparam logic [7:0] STATUS_OFS = 8'h1C;
    localparam logic [7:0] REVS_OFS = 8'h20;

    // Control register fields
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned CTRL_ACT_LSB = 4;
    localparam int unsigned CTRL_SRC_LSB = 8;

    // Reset values
    localparam logic [7:0] SRC_RST = 8'h00;
    localparam logic [29:0] DIST_RST = 30'h00000000;
    localparam logic [15:0] SIGCORR_RST = 16'h0000;
    localparam logic [15:0] LOADCORR_RST = 16'h0000;
    localparam logic [21:0] WAIT_RST = 22'h000000;
    localparam logic [15:0] DECEL_RST = 16'h0005;
    localparam logic [3:0] POLES_RST = 4'h2;

    // Limits and scale factors
    localparam logic [29:0] DIST_MAX = 30'h3B9ACA00;
    localparam logic [21:0] WAIT_MAX = 22'h36EE80;
    localparam logic [17:0] REV_STEP_UNIT = 18'h02710;
    localparam logic [23:0] DEC_UNIT = 24'h0003E8;
    localparam logic [63:0] BRAKE_SCALE = 64'h0000000000000014;

    // Reference source codes
    localparam logic [7:0] SRC_IN2_NEG = 8'h02;
    localparam logic [7:0] SRC_IN3_NEG = 8'h03;
    localparam logic [7:0] SRC_IN6_NEG = 8'h06;
    localparam logic [7:0] SRC_IN2_POS = 8'h0C;
    localparam logic [7:0] SRC_IN3_POS = 8'h0D;
    localparam logic [7:0] SRC_IN6_POS = 8'h10;
    localparam logic [7:0] SRC_IN2_BOTH = 8'h16;
    localparam logic [7:0] SRC_IN3_BOTH = 8'h17;
    localparam logic [7:0] SRC_IN6_BOTH = 8'h1A;

    typedef enum logic [2:0] {
        ACT_END = 3'h0,
        ACT_WAIT_EDGE = 3'h1,
        ACT_REV_EDGE = 3'h2,
        ACT_OFF = 3'h3,
        ACT_WAIT_TIME = 3'h4,
        ACT_REV_TIME = 3'h5
    } action_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DELAY = 3'b001,
        ST_TRAVEL = 3'b011,
        ST_DECEL = 3'b010,
        ST_PARK = 3'b110,
        ST_STOP = 3'b111
    } state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

endpackage : ref_pos_pkg

// *** edge_sync.sv ***
// Three-stage input synchroniser with qualified edge pulses
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic pin_in,
    output logic rise_q,
    output logic fall_q
);
    logic [2:0] sync_q;
    logic level_q;
    logic known_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync_q <= 3'h0;
            level_q <= 1'b0;
            known_q <= 1'b0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            sync_q <= {sync_q[1:0], pin_in};
            rise_q <= 1'b0;
            fall_q <= 1'b0;
            // Second and third stage must agree before a change counts
            if (sync_q[1] == sync_q[2]) begin
                known_q <= 1'b1;
                level_q <= sync_q[2];
                // First valid level after reset is not an edge
                if (known_q && sync_q[2] != level_q) begin
                    rise_q <= sync_q[2];
                    fall_q <= !sync_q[2];
                end
            end
        end
    end
endmodule : edge_sync
`default_nettype wire

// *** drive_stage_model.sv ***
// Drive stage model that follows the frequency reference
`timescale 1ns/1ps
`default_nettype none
module drive_stage_model #(
    parameter logic [15:0] SET_FREQ = 16'h07D0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [15:0] freq_ref_q,
    input wire logic freq_own_q,
    output logic [15:0] drive_freq
);
    // Ramps up to SET_FREQ while not owned so a reference can land mid-ramp
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            drive_freq <= 16'h0000;
        end else if (freq_own_q) begin
            drive_freq <= freq_ref_q;
        end else if (drive_freq < SET_FREQ) begin
            drive_freq <= drive_freq + 16'h0001;
        end
    end
endmodule : drive_stage_model
`default_nettype wire

// *** reference_positioning_control_tb.sv ***
// Self-checking bench for the reference positioning block
`timescale 1ns/1ps
`default_nettype none
module reference_positioning_control_tb;
    logic sys_clk = 1'b0, rst = 1'b1;
    logic [2:0] pin = 3'h0;
    logic [15:0] drive_freq, freq_ref_q;
    ref_pos_pkg::apb_req_t req = '0;
    ref_pos_pkg::apb_rsp_t rsp;
    logic own, stop, poff, rev, rstart;
    int n_mismatch = 0, n_checks = 0, cyc = 0;
    logic [31:0] rd;
    logic er;
    reference_positioning_control #(.TICK_CYCLES(20), .MS_TICKS(4)) dut (
        .sys_clk(sys_clk), .rst(rst), .digital_input_two(pin[0]),
        .digital_input_three(pin[1]), .digital_input_six(pin[2]),
        .drive_freq(drive_freq), .apb_req(req), .apb_rsp_q(rsp),
        .freq_ref_q(freq_ref_q), .freq_own_q(own), .stop_q(stop),
        .power_off_q(poff), .reverse_q(rev), .restart_q(rstart));
    drive_stage_model model (.sys_clk(sys_clk), .rst(rst),
        .freq_ref_q(freq_ref_q), .freq_own_q(own), .drive_freq(drive_freq));
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        // Whole run needs well under this
        if (cyc == 30000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge sys_clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb
    task automatic ctrl(logic [7:0] src, logic [2:0] act, logic en);
        apb(1'b1, ref_pos_pkg::CTRL_OFS, {16'h0000, src, 1'b0, act, 3'h0, en});
    endtask : ctrl
    task automatic edge_to(int k, logic v);
        @(posedge sys_clk);
        pin[k] <= v;
        repeat (8) @(posedge sys_clk);
    endtask : edge_to
    task automatic t_regs;
        apb(1'b0, ref_pos_pkg::DECEL_OFS, 32'h0);
        chk("decel", 32'h00000005, rd);
        apb(1'b0, ref_pos_pkg::POLES_OFS, 32'h0);
        chk("poles", 32'h00000002, rd);
        apb(1'b0, ref_pos_pkg::DIST_OFS, 32'h0);
        chk("dist", 32'h00000000, rd);
        apb(1'b1, 8'h24, 32'hFFFFFFFF);
        chk("unmapped err", 32'h1, {31'h0, er});
    endtask : t_regs
    task automatic t_disabled;
        ctrl(ref_pos_pkg::SRC_IN2_BOTH, 3'h0, 1'b0);
        edge_to(0, ~pin[0]);
        chk("own off", 32'h0, {31'h0, own});
    endtask : t_disabled
    task automatic t_sources;
        logic [7:0] s[9] = '{ref_pos_pkg::SRC_IN2_NEG, ref_pos_pkg::SRC_IN3_NEG,
            ref_pos_pkg::SRC_IN6_NEG, ref_pos_pkg::SRC_IN2_POS,
            ref_pos_pkg::SRC_IN3_POS, ref_pos_pkg::SRC_IN6_POS,
            ref_pos_pkg::SRC_IN2_BOTH, ref_pos_pkg::SRC_IN3_BOTH,
            ref_pos_pkg::SRC_IN6_BOTH};
        logic pre;
        for (int i = 0; i < 9; i++) begin
            pre = (i / 3 == 1);
            edge_to(i % 3, pre);
            ctrl(s[i], (i == 8) ? 3'h3 : 3'h0, 1'b1);
            edge_to(i % 3, !pre);
            if (i < 6) begin
                chk("wrong edge", 32'h0, {31'h0, own});
                edge_to(i % 3, pre);
            end
            chk("stop", 32'h1, {31'h0, stop});
            chk("freq", 32'h0, {16'h0, freq_ref_q});
            chk("power off", {31'h0, i == 8}, {31'h0, poff});
            ctrl(8'h00, 3'h0, 1'b0);
            repeat (3) @(posedge sys_clk);
            chk("released", 32'h0, {31'h0, own});
        end
    endtask : t_sources
    task automatic t_park(logic [2:0] act, int lo, int hi);
        int n = 0;
        logic r0;
        apb(1'b1, ref_pos_pkg::WAIT_OFS, 32'h1);
        ctrl(ref_pos_pkg::SRC_IN2_BOTH, act, 1'b1);
        r0 = rev;
        edge_to(0, ~pin[0]);
        chk("park", 32'h1, {31'h0, stop});
        if (act == 3'h1 || act == 3'h2) begin
            @(posedge sys_clk);
            pin[0] <= ~pin[0];
        end
        while (rstart !== 1'b1 && n < 300) begin
            @(posedge sys_clk);
            n++;
        end
        chk("wait ok", 32'h1, {31'h0, n >= lo && n <= hi});
        @(posedge sys_clk);
        chk("dir", {31'h0, r0 ^ (act == 3'h2 || act == 3'h5)}, {31'h0, rev});
        ctrl(8'h00, 3'h0, 1'b0);
    endtask : t_park
    task automatic t_travel;
        apb(1'b1, ref_pos_pkg::DIST_OFS, 32'h0000000F);
        apb(1'b1, ref_pos_pkg::LOADCORR_OFS, 32'h00000005);
        apb(1'b1, ref_pos_pkg::DECEL_OFS, 32'h00002710);
        // Event lands mid-ramp, so the frozen frequency is not a round value
        repeat (1000) @(posedge sys_clk);
        ctrl(ref_pos_pkg::SRC_IN6_NEG, 3'h0, 1'b1);
        edge_to(2, 1'b0);
        chk("travel own", 32'h1, {31'h0, own});
        while (stop !== 1'b1) begin
            @(posedge sys_clk);
        end
        chk("travel freq", 32'h0, {16'h0, freq_ref_q});
        apb(1'b0, ref_pos_pkg::REVS_OFS, 32'h0);
        // Target is distance 15 plus load 5, a few mrev of slack
        chk("revs", 32'h1, {31'h0, rd > 32'h11 && rd < 32'h17});
        ctrl(8'h00, 3'h0, 1'b0);
    endtask : t_travel
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        t_regs();
        t_disabled();
        t_sources();
        t_park(3'h1, 1, 20);
        t_park(3'h2, 1, 20);
        t_park(3'h4, 50, 120);
        t_park(3'h5, 50, 120);
        t_travel();
        end_of_test();
    end
endmodule : reference_positioning_control_tb
`default_nettype wire
